//--- sim/tb_top.sv
// Self-checking bench for the clock switch and wakeup control.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import clk_ctrl_pkg::*;
   // ==========================================================
   // Stimulus, observation and model state
   logic       sys_clk, resetn, clock_mode_reg_wr, xtal_wr, misc_wr;
   logic [7:0] clock_mode_reg_wdata, xtal_wdata, misc_wdata;
   logic       halt_req, wake_evt, wdt_clear, rst_in;
   logic [2:0] lvr_code, lvl_q, src_q;
   logic       tick_pin, rst_pin, xtal_ok, por_ok, tick_on;
   logic [7:0] mode_q, xtal_q, misc_q;
   logic       wdt_run, wdt_rst, hang, down, ext_rst, lvr_en;
   int         mismatches, n_compared, m_mode, m_hang, m_xtal, n, i;

   clk_switch_ctrl #(.WDT_LIMIT(8), .SLOW_WAKE(4), .EMULATION(1'b0)) dut (
      .sys_clk(sys_clk), .resetn(resetn),
      .clock_mode_reg_wr(clock_mode_reg_wr), .clock_mode_reg_wdata(clock_mode_reg_wdata),
      .xtal_wr(xtal_wr), .xtal_wdata(xtal_wdata),
      .misc_wr(misc_wr), .misc_wdata(misc_wdata),
      .halt_req(halt_req), .wake_evt(wake_evt), .wdt_clear(wdt_clear),
      .rst_pin_is_input(rst_in), .lvr_code(lvr_code),
      .low_rc_tick_pin(tick_pin), .reset_capable_pin(rst_pin),
      .crystal_ok_pin(xtal_ok), .por_ok_pin(por_ok),
      .clock_mode_reg(mode_q), .crystal_ctrl_reg(xtal_q),
      .misc_reg(misc_q), .sys_src(src_q), .wdt_running(wdt_run),
      .wdt_reset(wdt_rst), .core_hang(hang), .powered_down(down),
      .ext_reset_input(ext_rst), .low_voltage_reset_en(lvr_en),
      .lvr_level(lvl_q));

   // ==========================================================
   // Clocks: the low RC wave has a period of four system clocks.
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always #50 if (tick_on) tick_pin = ~tick_pin;

   // ==========================================================
   // Shared tasks
   task automatic cyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask

   task automatic chk(input string nm, input logic [7:0] seen,
                      input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rst();
      resetn = 1'b0;
      cyc(16);
      resetn = 1'b1;
      m_mode = 8'hf6;
      m_hang = 0;
      m_xtal = 0;
   endtask

   // The model flags a hang when the select moves while the old source
   // is switched off, or when an unsettled crystal is selected.
   task automatic wr_mode(input logic [7:0] v);
      int os, ns;
      os = m_mode[7:5];
      ns = v[7:5];
      if (m_hang == 0) begin
         if (ns != os && ((os == 7 && !v[2]) || (os < 3 && !v[4]) ||
             (ns == 5 && !(xtal_ok && m_xtal[7]))))
            m_hang = 1;
         m_mode = v;
      end
      clock_mode_reg_wr = 1'b1;
      clock_mode_reg_wdata = v;
      cyc(1);
      clock_mode_reg_wr = 1'b0;
      chk("mode", mode_q, m_mode[7:0]);
      chk("src", src_q, m_mode[7:5]);
      cyc(1);
      chk("hang", hang, m_hang[7:0]);
   endtask

   task automatic cnt_rst(input int k);
      n = 0;
      repeat (k) begin
         cyc(1);
         n += wdt_rst;
      end
   endtask

   task automatic wr_misc(input logic [7:0] v);
      misc_wr = 1'b1;
      misc_wdata = v;
      cyc(1);
      misc_wr = 1'b0;
      cyc(1);
   endtask

   // Halt, wake, then measure how long power-down lasts.
   task automatic halt_wake(input int lo, input int hi);
      halt_req = 1'b1;
      cyc(1);
      halt_req = 1'b0;
      cyc(1);
      chk("down", down, 1);
      wake_evt = 1'b1;
      cyc(1);
      wake_evt = 1'b0;
      n = 0;
      while (down === 1'b1 && n < 1000) begin
         cyc(1);
         n++;
      end
      chk("wake_len", (n >= lo && n <= hi), 1);
   endtask

   task automatic fin(input string nm);
      $display("test %s done", nm);
   endtask

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // A hung handshake must not stall the run forever.
   initial begin
      #500000;
      mismatches++;
      end_of_test();
   end

   // ==========================================================
   // Main sequence
   initial begin
      {clock_mode_reg_wr, xtal_wr, misc_wr, halt_req, wake_evt} = '0;
      {wdt_clear, rst_in, tick_pin, xtal_ok, por_ok, tick_on} = '0;
      {clock_mode_reg_wdata, xtal_wdata, misc_wdata, lvr_code} = '0;
      rst_pin = 1'b1;
      mismatches = 0;
      n_compared = 0;
      void'($urandom(63582));
      rst();
      chk("mode_rst", mode_q, 8'hf6);
      wr_mode(8'h36);
      wr_mode(8'h32);
      fin("high_rc_switch");
      rst();
      wr_mode(8'h50);
      wr_mode(8'h36);
      fin("one_write_hang");
      rst();
      xtal_wr = 1'b1;
      for (i = 1; i < 4; i++) begin
         xtal_wdata = {1'b1, i[1:0], 5'h00};
         m_xtal = xtal_wdata;
         cyc(1);
         chk("xtal", xtal_q, m_xtal[7:0]);
      end
      xtal_wr = 1'b0;
      xtal_ok = 1'b1;
      cyc(4);
      wr_mode(8'ha6);
      wr_mode(8'ha4);
      fin("crystal_switch");
      rst();
      xtal_ok = 1'b0;
      cyc(4);
      wr_mode(8'ha6);
      fin("crystal_unsettled");
      rst();
      for (i = 0; i < 3; i++) begin
         lvr_code = $urandom;
         cyc(2);
         chk("lvl", lvl_q, lvr_code);
      end
      por_ok = 1'b1;
      cyc(5);
      n = lvr_code;
      lvr_code = ~lvr_code;
      cyc(2);
      chk("lvl_frozen", lvl_q, n[7:0]);
      for (i = 0; i < 4; i++) begin
         wr_misc($urandom);
         chk("misc", misc_q, misc_wdata);
         chk("lvr_en", lvr_en, !misc_wdata[2]);
      end
      fin("low_voltage_reset");
      rst();
      wr_mode(8'hf7);
      rst_in = 1'b1;
      rst_pin = 1'b0;
      cyc(5);
      chk("ext_rst", ext_rst, 1);
      rst_in = 1'b0;
      cyc(2);
      chk("ext_rst_out", ext_rst, 0);
      rst_pin = 1'b1;
      fin("reset_pin");
      rst();
      tick_on = 1'b1;
      cnt_rst(140);
      chk("wdt_slow", n[7:0], 8'h04);
      chk("wdt_on", wdt_run, 1);
      wr_misc(8'h20);
      cnt_rst(80);
      chk("wdt_fast", n[7:0], 8'h0a);
      wdt_clear = 1'b1;
      cnt_rst(40);
      chk("wdt_clr", n[7:0], 8'h00);
      wdt_clear = 1'b0;
      wr_misc(8'h00);
      wr_mode(8'hf2);
      chk("wdt_run", wdt_run, 0);
      cnt_rst(64);
      chk("wdt_stop", n[7:0], 8'h00);
      fin("watchdog");
      rst();
      tick_on = 1'b1;
      wr_mode(8'hf4);
      wr_misc(8'h20);
      halt_wake(178, 181);
      wr_misc(8'h00);
      halt_wake(14, 17);
      fin("wakeup");
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire

//--- src/clk_ctrl_pkg.sv
// Constants shared by the clock switch and wakeup control design.
package clk_ctrl_pkg;
   // =========================================================
   // Clock mode register layout
   localparam int          SEL_HI   = 7;
   localparam int          SEL_LO   = 5;
   localparam int          HIGH_EN  = 4;
   localparam int          LOW_EN   = 2;
   localparam int          WDT_EN   = 1;
   localparam int          RST_PIN  = 0;
   localparam logic [7:0]  CLOCK_MODE_REG_RESET     = 8'hf6;
   localparam logic [7:0]  CLOCK_MODE_REG_HI_DIV2   = 8'h36;
   localparam logic [7:0]  CLOCK_MODE_REG_XTAL_KEEP = 8'ha6;
   localparam logic [2:0]  SRC_HIGH_DIV2   = 3'h1;
   localparam logic [2:0]  SRC_HIGH_DIV4   = 3'h2;
   localparam logic [2:0]  SRC_CRYSTAL     = 3'h5;
   localparam logic [2:0]  SRC_LOW_RC      = 3'h7;
   // =========================================================
   // Crystal control and auxiliary control layout
   localparam int          XTAL_EN  = 7;
   localparam int          DRV_HI   = 6;
   localparam int          DRV_LO   = 5;
   localparam logic [7:0]  XTAL_RESET      = 8'h00;
   localparam int          LVR_OFF  = 2;
   localparam int          FAST_WK  = 5;
   localparam logic [7:0]  MISC_RESET      = 8'h00;
   // Synchroniser idle levels: status pins low, reset pin high, tick low.
   localparam logic [3:0]  SYNC_IDLE       = 4'h2;
   // =========================================================
   // Timing counts
   localparam int          FAST_WAKE_TICKS = 45;
   localparam int          EMU_WAKE_CYCLES = 128;
   localparam int          SLOW_WAKE_TICKS = 1024;
   localparam int          WDT_TICKS       = 256;
   localparam int          CNT_W           = 16;
   typedef enum logic [1:0] {
      PWR_RUN  = 2'b00,
      PWR_DOWN = 2'b01,
      PWR_WAKE = 2'b10
   } pwr_state_t;
endpackage

//--- src/clk_switch_ctrl.sv
// Clock source switching, watchdog source and power-down control.
// Behaviour
// - Writing 0x36 selects the high RC divided by two and keeps the low RC on.
// - Writing 0xa6 selects the crystal and keeps the low RC on until a later write.
// - The crystal is accepted without any check, and selecting it unsettled hangs the core.
// - Without fast wakeup, the watchdog stops while the low RC that clocks it is disabled.
// - The watchdog counts low RC periods normally and system clocks under fast wakeup.
// - Fast wakeup takes 45 low RC periods, or 128 system clocks in emulation.
// - Auxiliary bit 2 disables low-voltage reset, whose level holds only after power-on.
// - Crystal control bit 7 enables the crystal and bits 6 to 5 pick its drive band.
// - Clock mode bit 0 makes the reset-capable pin an active-low reset when it is an input.
`timescale 1ns/100ps
`default_nettype none
module clk_switch_ctrl
   import clk_ctrl_pkg::*;
#(
   parameter int WDT_LIMIT  = WDT_TICKS,
   parameter int SLOW_WAKE  = SLOW_WAKE_TICKS,
   parameter bit EMULATION  = 1'b0
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   // Register writes from the core
   input  wire logic       clock_mode_reg_wr,
   input  wire logic [7:0] clock_mode_reg_wdata,
   input  wire logic       xtal_wr,
   input  wire logic [7:0] xtal_wdata,
   input  wire logic       misc_wr,
   input  wire logic [7:0] misc_wdata,
   // Core events
   input  wire logic       halt_req,
   input  wire logic       wake_evt,
   input  wire logic       wdt_clear,
   input  wire logic       rst_pin_is_input,
   input  wire logic [2:0] lvr_code,
   // Pins and analog status
   input  wire logic       low_rc_tick_pin,
   input  wire logic       reset_capable_pin,
   input  wire logic       crystal_ok_pin,
   input  wire logic       por_ok_pin,
   // Register contents
   output logic [7:0]      clock_mode_reg,
   output logic [7:0]      crystal_ctrl_reg,
   output logic [7:0]      misc_reg,
   // Status and control
   output logic [2:0]      sys_src,
   output logic            wdt_running,
   output logic            wdt_reset,
   output logic            core_hang,
   output logic            powered_down,
   output logic            ext_reset_input,
   output logic            low_voltage_reset_en,
   output logic [2:0]      lvr_level
);
   logic [3:0]       meta_r;
   logic [3:0]       sync_r;
   logic             tick_prev_r;
   logic             rc_rise;
   logic [CNT_W-1:0] wdt_cnt_r;
   logic             wdt_run;
   logic             wdt_step;
   logic             fast;
   logic             bad_switch;
   pwr_state_t       state_r;
   wake_if           wk ();

   // Tells whether a source stays powered under a given mode value.
   function automatic logic src_on(input logic [2:0] s,
                                   input logic [7:0] md);
      if (s == SRC_LOW_RC)
         return md[LOW_EN];
      else if (s == SRC_HIGH_DIV2 || s == SRC_HIGH_DIV4)
         return md[HIGH_EN];
      else
         return 1'b1;
   endfunction

   // =========================================================
   // Pin synchronisers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         // Idle levels keep a false tick edge and reset request away.
         meta_r      <= SYNC_IDLE;
         sync_r      <= SYNC_IDLE;
         tick_prev_r <= 1'b0;
      end else begin
         meta_r      <= {por_ok_pin, crystal_ok_pin, reset_capable_pin,
                         low_rc_tick_pin};
         sync_r      <= meta_r;
         tick_prev_r <= sync_r[0];
      end
   end
   assign rc_rise = sync_r[0] && !tick_prev_r;

   // =========================================================
   // Mode registers and source switching
   // A bad switch is flagged rather than blocked, since the real core
   // simply stops and nothing short of reset recovers it.
   assign bad_switch = clock_mode_reg_wr && !core_hang && (
      (clock_mode_reg_wdata[SEL_HI:SEL_LO] != clock_mode_reg[SEL_HI:SEL_LO]
       && !src_on(clock_mode_reg[SEL_HI:SEL_LO], clock_mode_reg_wdata))
      || (clock_mode_reg_wdata[SEL_HI:SEL_LO] == SRC_CRYSTAL
          && !(sync_r[2] && crystal_ctrl_reg[XTAL_EN])));

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         clock_mode_reg <= CLOCK_MODE_REG_RESET;
         sys_src        <= SRC_LOW_RC;
         core_hang      <= 1'b0;
      end else if (clock_mode_reg_wr && !core_hang) begin
         clock_mode_reg <= clock_mode_reg_wdata;
         sys_src        <= clock_mode_reg_wdata[SEL_HI:SEL_LO];
         core_hang      <= bad_switch;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         crystal_ctrl_reg <= XTAL_RESET;
         misc_reg         <= MISC_RESET;
      end else begin
         if (xtal_wr)
            crystal_ctrl_reg <= xtal_wdata;
         if (misc_wr)
            misc_reg <= misc_wdata;
      end
   end

   // =========================================================
   // Watchdog
   assign fast     = misc_reg[FAST_WK];
   assign wdt_run  = clock_mode_reg[WDT_EN]
                     && (fast || clock_mode_reg[LOW_EN]);
   assign wdt_step = fast ? 1'b1 : rc_rise;

   // The count continues through power-down, so a halt with the
   // watchdog left on ends in a watchdog reset.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wdt_cnt_r   <= '0;
         wdt_reset   <= 1'b0;
         wdt_running <= 1'b0;
      end else begin
         wdt_reset   <= 1'b0;
         wdt_running <= wdt_run;
         if (wdt_clear || !clock_mode_reg[WDT_EN]) begin
            wdt_cnt_r <= '0;
         end else if (wdt_run && wdt_step) begin
            if (wdt_cnt_r == CNT_W'(WDT_LIMIT - 1)) begin
               wdt_cnt_r <= '0;
               wdt_reset <= 1'b1;
            end else begin
               wdt_cnt_r <= wdt_cnt_r + 1'b1;
            end
         end
      end
   end

   // =========================================================
   // Power-down and wakeup
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r      <= PWR_RUN;
         powered_down <= 1'b0;
      end else begin
         case (state_r)
            PWR_RUN: begin
               if (halt_req) begin
                  state_r      <= PWR_DOWN;
                  powered_down <= 1'b1;
               end
            end
            PWR_DOWN: begin
               if (wake_evt)
                  state_r <= PWR_WAKE;
            end
            PWR_WAKE: begin
               if (wk.done) begin
                  state_r      <= PWR_RUN;
                  powered_down <= 1'b0;
               end
            end
            default: state_r <= PWR_RUN;
         endcase
      end
   end
   assign wk.start   = (state_r == PWR_DOWN) && wake_evt;
   assign wk.fast    = fast;
   assign wk.rc_tick = rc_rise;

   wakeup_timer #(
      .SLOW_TICKS (SLOW_WAKE),
      .EMULATION  (EMULATION)
   ) u_wake (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .wk      (wk.timer)
   );

   // =========================================================
   // Reset pin and low-voltage reset
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ext_reset_input      <= 1'b0;
         low_voltage_reset_en <= 1'b0;
         lvr_level            <= 3'h0;
      end else begin
         ext_reset_input <= clock_mode_reg[RST_PIN] && rst_pin_is_input
                            && !sync_r[1];
         low_voltage_reset_en <= sync_r[3] && !misc_reg[LVR_OFF];
         if (!sync_r[3])
            lvr_level <= lvr_code;
      end
   end

   // =========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   hi_div2_a: assert property (clock_mode_reg_wr && !core_hang
      && clock_mode_reg_wdata == CLOCK_MODE_REG_HI_DIV2 |=> sys_src == SRC_HIGH_DIV2
      && clock_mode_reg[LOW_EN])
      else $error("High RC switch did not keep the low RC running.");
   xtal_keep_a: assert property (clock_mode_reg_wr && !core_hang
      && clock_mode_reg_wdata == CLOCK_MODE_REG_XTAL_KEEP |=> sys_src == SRC_CRYSTAL
      && clock_mode_reg[LOW_EN])
      else $error("Crystal switch did not keep the low RC running.");
   xtal_nocheck_a: assert property (clock_mode_reg_wr && !core_hang && !sync_r[2]
      && clock_mode_reg_wdata[SEL_HI:SEL_LO] == SRC_CRYSTAL
      |=> sys_src == SRC_CRYSTAL && core_hang)
      else $error("Unsettled crystal was refused or did not hang.");
   wdt_stop_a: assert property (!clock_mode_reg[LOW_EN] && !fast
      && clock_mode_reg[WDT_EN] && !wdt_clear
      |=> $stable(wdt_cnt_r) && !wdt_reset)
      else $error("Watchdog counted with its clock stopped.");
   wdt_fast_a: assert property (wdt_run && fast && !wdt_clear
      && wdt_cnt_r < CNT_W'(WDT_LIMIT - 1)
      |=> wdt_cnt_r == $past(wdt_cnt_r) + 1'b1)
      else $error("Watchdog missed a system clock under fast wakeup.");
   wdt_slow_a: assert property (wdt_run && !fast && !rc_rise && !wdt_clear
      |=> $stable(wdt_cnt_r))
      else $error("Watchdog counted without a low RC period.");
   lvr_off_a: assert property (misc_reg[LVR_OFF] || !sync_r[3]
      |=> !low_voltage_reset_en)
      else $error("Low-voltage reset on while disabled or before power-on.");
   drive_band_a: assert property (xtal_wr |=> crystal_ctrl_reg[DRV_HI:DRV_LO]
      == $past(xtal_wdata[DRV_HI:DRV_LO])
      && crystal_ctrl_reg[XTAL_EN] == $past(xtal_wdata[XTAL_EN]))
      else $error("Crystal enable or drive band not taken.");
   ext_reset_a: assert property (ext_reset_input
      |-> $past(clock_mode_reg[RST_PIN]) && $past(rst_pin_is_input))
      else $error("External reset active without pin set up for it.");

   hang_c: cover property (bad_switch);
   wake_c: cover property (state_r == PWR_WAKE && wk.done);
   wdt_c:  cover property (wdt_reset && powered_down);
   xtal_c: cover property (sys_src == SRC_CRYSTAL && !core_hang);
endmodule // clk_switch_ctrl
`default_nettype wire

//--- src/wake_if.sv
// Handshake between the power controller and its wakeup timer.
`timescale 1ns/100ps
`default_nettype none
interface wake_if;
   logic start;
   logic fast;
   logic rc_tick;
   logic done;
   modport ctrl  (output start, output fast, output rc_tick, input done);
   modport timer (input start, input fast, input rc_tick, output done);
endinterface
`default_nettype wire

//--- src/wakeup_timer.sv
// Wakeup delay counter for leaving power-down.
`timescale 1ns/100ps
`default_nettype none
module wakeup_timer
   import clk_ctrl_pkg::*;
#(
   parameter int FAST_TICKS = FAST_WAKE_TICKS,
   parameter int EMU_CYCLES = EMU_WAKE_CYCLES,
   parameter int SLOW_TICKS = SLOW_WAKE_TICKS,
   parameter bit EMULATION  = 1'b0
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic resetn,
   // Controller side
   wake_if.timer     wk
);
   logic [CNT_W-1:0] cnt_r;
   logic             run_r;
   logic             done_r;
   logic             step;
   logic [CNT_W-1:0] target;

   // =========================================================
   // Counting
   // Under fast wakeup the emulation build counts system clocks instead of RC periods.
   always_comb begin
      step   = wk.rc_tick;
      target = CNT_W'(SLOW_TICKS - 1);
      if (wk.fast && EMULATION) begin
         step   = 1'b1;
         target = CNT_W'(EMU_CYCLES - 1);
      end else if (wk.fast) begin
         target = CNT_W'(FAST_TICKS - 1);
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r  <= '0;
         run_r  <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (wk.start) begin
            cnt_r <= '0;
            run_r <= 1'b1;
         end else if (run_r && step) begin
            if (cnt_r == target) begin
               run_r  <= 1'b0;
               done_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end
   assign wk.done = done_r;

   fast_wake_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      run_r && wk.fast && !EMULATION && !wk.start && wk.rc_tick
      && cnt_r == CNT_W'(FAST_TICKS - 1) |=> done_r)
      else $error("Fast wakeup did not end after its RC periods.");
   wake_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      run_r && !wk.start && !step |=> !done_r && $stable(cnt_r))
      else $error("Wakeup counter moved without a tick.");
endmodule // wakeup_timer
`default_nettype wire
